// file: logic/pfl_loop.sv
// PI fan loop configuration registers and the loop that uses them.
// Assumes zone temperatures in signed 8-bit, 1 degree per LSB, with 9-bit
// half-degree readings supplied; register port is synchronous to ref_clk.
`timescale 1ns/1ps
module pfl_loop #(
  parameter int UPDATE_CYC = pfl_pkg::PFL_UPDATE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire pfl_pkg::pfl_req_t req,
  input  wire pfl_pkg::pfl_bind_t bind_cfg,
  input  wire logic [8:0]        zone1_temp,
  input  wire logic [8:0]        zone2_temp,
  input  wire logic [7:0]        pwm1_lut_duty,
  input  wire logic [7:0]        pwm2_lut_duty,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic [7:0]             loop_duty,
  output logic [7:0]             pwm1_duty,
  output logic [7:0]             pwm2_duty
);
  import pfl_pkg::*;

  // Tick counter is 16 bits and needs at least two states
  if (UPDATE_CYC < 2 || UPDATE_CYC > 65535) begin : g_bad_update_cyc
    $error("UPDATE_CYC out of range");
  end

  // Whole module state, registered in one place
  typedef struct packed {
    pfl_regs_t    regs;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [15:0]  tick;
    logic signed [17:0] integ;
    logic [7:0]   duty;
    logic [7:0]   pwm1;
    logic [7:0]   pwm2;
  } pfl_state_t;

  pfl_state_t s_q;
  pfl_state_t s_d;

  // Signed shift by a 2-bit exponent, -2..+1
  function automatic logic signed [19:0] pfl_scale(input logic signed [19:0] v,
                                                   input logic [1:0] e);
    case (e)
      2'b10:   pfl_scale = v >>> 2;
      2'b11:   pfl_scale = v >>> 1;
      2'b01:   pfl_scale = v <<< 1;
      default: pfl_scale = v;
    endcase
  endfunction

  // Off-temperature match on the whole-degree part of a half-degree reading
  function automatic logic pfl_at_off(input logic [8:0] t, input logic [7:0] off);
    pfl_at_off = (off != PFL_OFF_DISABLED) && ($signed(t[8:1]) >= $signed(off));
  endfunction

  logic signed [8:0]  hot_t;
  logic signed [8:0]  tgt_t;
  logic signed [9:0]  err;
  logic signed [19:0] p_term;
  logic signed [19:0] i_step;
  logic signed [19:0] i_next;
  logic signed [19:0] sum;
  logic [7:0]         floor_duty;
  logic               any_zone;
  logic               force_off;

  always_comb begin
    s_d        = s_q;
    hot_t      = '0;
    tgt_t      = '0;
    err        = '0;
    p_term     = '0;
    i_step     = '0;
    i_next     = '0;
    sum        = '0;
    any_zone   = 1'b0;
    force_off  = 1'b0;
    s_d.rvalid = req.rd_en;
    s_d.rdata  = 8'h00;
    // Read decode; unmapped offsets answer zero
    if (req.rd_en) begin
      if (req.addr == PFL_OFF_MIN_HYST) begin
        s_d.rdata = {s_q.regs.loop_min_duty, s_q.regs.loop_hysteresis};
      end else if (req.addr == PFL_OFF_Z1_TGT) begin
        s_d.rdata = s_q.regs.zone1_target_temp;
      end else if (req.addr == PFL_OFF_Z2_TGT) begin
        s_d.rdata = s_q.regs.zone2_target_temp;
      end else if (req.addr == PFL_OFF_Z1_OFF) begin
        s_d.rdata = s_q.regs.zone1_off_temp;
      end else if (req.addr == PFL_OFF_Z2_OFF) begin
        s_d.rdata = s_q.regs.zone2_off_temp;
      end else if (req.addr == PFL_OFF_P_GAIN) begin
        s_d.rdata = s_q.regs.proportional_gain;
      end else if (req.addr == PFL_OFF_I_GAIN) begin
        s_d.rdata = s_q.regs.integral_gain;
      end else if (req.addr == PFL_OFF_EXP) begin
        s_d.rdata = {4'h0, s_q.regs.proportional_exponent, s_q.regs.integral_exponent};
      end
    end
    // Write decode; unmapped offsets are ignored
    if (req.wr_en) begin
      if (req.addr == PFL_OFF_MIN_HYST) begin
        s_d.regs.loop_min_duty   = req.wdata[7:4];
        s_d.regs.loop_hysteresis = req.wdata[3:0];
      end else if (req.addr == PFL_OFF_Z1_TGT) begin
        s_d.regs.zone1_target_temp = req.wdata;
      end else if (req.addr == PFL_OFF_Z2_TGT) begin
        s_d.regs.zone2_target_temp = req.wdata;
      end else if (req.addr == PFL_OFF_Z1_OFF) begin
        s_d.regs.zone1_off_temp = req.wdata;
      end else if (req.addr == PFL_OFF_Z2_OFF) begin
        s_d.regs.zone2_off_temp = req.wdata;
      end else if (req.addr == PFL_OFF_P_GAIN) begin
        s_d.regs.proportional_gain = req.wdata;
      end else if (req.addr == PFL_OFF_I_GAIN) begin
        s_d.regs.integral_gain = req.wdata;
      end else if (req.addr == PFL_OFF_EXP) begin
        s_d.regs.proportional_exponent = req.wdata[3:2];
        s_d.regs.integral_exponent     = req.wdata[1:0];
      end
    end

    // zone selection, hottest bound zone wins
    if (bind_cfg.loop_uses_zone1) begin
      hot_t    = $signed(zone1_temp);
      tgt_t    = $signed({s_q.regs.zone1_target_temp, 1'b0});
      any_zone = 1'b1;
    end
    if (bind_cfg.loop_uses_zone2 &&
        (!any_zone || $signed(zone2_temp) > hot_t)) begin
      hot_t    = $signed(zone2_temp);
      tgt_t    = $signed({s_q.regs.zone2_target_temp, 1'b0});
      any_zone = 1'b1;
    end

    // error zero inside target band, hysteresis in half degrees
    if (hot_t > tgt_t) begin
      err = 10'(hot_t - tgt_t);
    end else if (hot_t < tgt_t - $signed({5'b0, s_q.regs.loop_hysteresis})) begin
      err = 10'(hot_t - (tgt_t - $signed({5'b0, s_q.regs.loop_hysteresis})));
    end

    // gains times two to the exponent
    p_term = pfl_scale(20'(err * $signed({1'b0, s_q.regs.proportional_gain})),
                       s_q.regs.proportional_exponent);
    i_step = pfl_scale(20'(err * $signed({1'b0, s_q.regs.integral_gain})),
                       s_q.regs.integral_exponent) >>> 4;
    // Integrator saturates so a long excursion cannot wind it up
    i_next = 20'(s_q.integ) + i_step;
    if (i_next < 0) begin
      i_next = '0;
    end else if (i_next > 20'sd65535) begin
      i_next = 20'sd65535;
    end

    force_off = (bind_cfg.loop_uses_zone1 &&
                 pfl_at_off(zone1_temp, s_q.regs.zone1_off_temp)) ||
                (bind_cfg.loop_uses_zone2 &&
                 pfl_at_off(zone2_temp, s_q.regs.zone2_off_temp));

    // Duty floor: sixteen counts per minimum-duty step
    floor_duty = {s_q.regs.loop_min_duty, 4'h0};
    // Loop update strobe every UPDATE_CYC cycles
    s_d.tick   = (s_q.tick >= 16'(UPDATE_CYC - 1)) ? 16'h0000 : s_q.tick + 16'h0001;
    if (s_q.tick == 16'h0000) begin
      s_d.integ = force_off || !any_zone ? '0 : 18'(i_next);
      sum       = (i_next >>> 8) + (p_term >>> 4);
      if (force_off) begin
        s_d.duty = 8'h00;
      // No bound zone leaves the loop at its floor
      end else if (!any_zone) begin
        s_d.duty = floor_duty;
      // duty clamped to floor and full scale
      end else if (sum > 20'sd255) begin
        s_d.duty = 8'hFF;
      end else if (sum < $signed({12'h000, floor_duty})) begin
        s_d.duty = floor_duty;
      end else begin
        s_d.duty = sum[7:0];
      end
    end

    s_d.pwm1 = bind_cfg.out1_from_loop ? s_q.duty : pwm1_lut_duty;
    s_d.pwm2 = bind_cfg.out2_from_loop ? s_q.duty : pwm2_lut_duty;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q      <= '0;
      s_q.regs.zone1_off_temp <= PFL_RST_OFF_TEMP;
      s_q.regs.zone2_off_temp <= PFL_RST_OFF_TEMP;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata     = s_q.rdata;
  assign rvalid    = s_q.rvalid;
  assign loop_duty = s_q.duty;
  assign pwm1_duty = s_q.pwm1;
  assign pwm2_duty = s_q.pwm2;
endmodule // pfl_loop

// file: shared/pfl_pkg.sv
// Package for the fan-loop configuration bank: offsets, reset values, field layout.
// Assumes an 8-bit register port decoded by the management interface outside.
package pfl_pkg;
  localparam logic [7:0] PFL_OFF_MIN_HYST = 8'h36;
  localparam logic [7:0] PFL_OFF_Z1_TGT   = 8'h37;
  localparam logic [7:0] PFL_OFF_Z2_TGT   = 8'h38;
  localparam logic [7:0] PFL_OFF_Z1_OFF   = 8'h39;
  localparam logic [7:0] PFL_OFF_Z2_OFF   = 8'h3A;
  localparam logic [7:0] PFL_OFF_P_GAIN   = 8'h3B;
  localparam logic [7:0] PFL_OFF_I_GAIN   = 8'h3C;
  localparam logic [7:0] PFL_OFF_EXP      = 8'h3D;
  localparam logic [7:0] PFL_RST_ZERO     = 8'h00;
  localparam logic [7:0] PFL_RST_OFF_TEMP = 8'h80;
  localparam logic [7:0] PFL_OFF_DISABLED = 8'h80;
  localparam logic [3:0] PFL_EXP_MASK     = 4'hF;
  localparam int         PFL_UPDATE_CYC   = 1024;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfl_req_t;

  typedef struct packed {
    logic       loop_uses_zone1;
    logic       loop_uses_zone2;
    logic       out1_from_loop;
    logic       out2_from_loop;
  } pfl_bind_t;

  typedef struct packed {
    logic [3:0] loop_min_duty;
    logic [3:0] loop_hysteresis;
    logic [7:0] zone1_target_temp;
    logic [7:0] zone2_target_temp;
    logic [7:0] zone1_off_temp;
    logic [7:0] zone2_off_temp;
    logic [7:0] proportional_gain;
    logic [7:0] integral_gain;
    logic [1:0] proportional_exponent;
    logic [1:0] integral_exponent;
  } pfl_regs_t;
endpackage

// file: verif/pfl_loop_monitor.sv
// Port assertions for the fan-loop register bank.
// Bound into pfl_loop; a shadow copy predicts read data.
`timescale 1ns/1ps
module pfl_loop_monitor (
  input wire logic               ref_clk,
  input wire logic               srst,
  input wire pfl_pkg::pfl_req_t  req,
  input wire pfl_pkg::pfl_bind_t bind_cfg,
  input wire logic [7:0]         pwm1_lut_duty,
  input wire logic [7:0]         pwm2_lut_duty,
  input wire logic [7:0]         rdata,
  input wire logic               rvalid,
  input wire logic [7:0]         loop_duty,
  input wire logic [7:0]         pwm1_duty,
  input wire logic [7:0]         pwm2_duty
);
  import pfl_pkg::*;
  logic [7:0] shadow_q [8];
  logic [2:0] idx;
  logic       mapped;
  logic [7:0] exp_rd;
  assign idx = 3'(req.addr - PFL_OFF_MIN_HYST);
  assign mapped = req.addr inside {[PFL_OFF_MIN_HYST:PFL_OFF_EXP]};
  assign exp_rd = !mapped ? 8'h00 : (idx == 3'h7) ? {4'h0, shadow_q[7][3:0]} : shadow_q[idx];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shadow_q <= '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    end else if (req.wr_en && mapped) begin
      shadow_q[idx] <= req.wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_read_answer: assert property (req.rd_en |=> rvalid)
    else $error("read unanswered");
  chk_no_stray: assert property (!req.rd_en |=> !rvalid)
    else $error("stray rvalid");
  chk_idle_zero: assert property (!rvalid |-> rdata == 8'h00)
    else $error("rdata not idle");
  chk_read_data: assert property (req.rd_en |=> rdata == $past(exp_rd))
    else $error("bad read data");
  chk_out1_lut: assert property (!bind_cfg.out1_from_loop |=> pwm1_duty == $past(pwm1_lut_duty))
    else $error("out1 not lut");
  chk_out2_lut: assert property (!bind_cfg.out2_from_loop |=> pwm2_duty == $past(pwm2_lut_duty))
    else $error("out2 not lut");
  chk_out1_loop: assert property (bind_cfg.out1_from_loop |=> pwm1_duty == $past(loop_duty))
    else $error("out1 not loop");
  chk_out2_loop: assert property (bind_cfg.out2_from_loop |=> pwm2_duty == $past(loop_duty))
    else $error("out2 not loop");
  cover property (req.rd_en && req.addr == PFL_OFF_EXP);
  cover property (bind_cfg.loop_uses_zone1 && loop_duty == 8'h00);
  cover property (req.wr_en ##2 req.rd_en);
endmodule // pfl_loop_monitor
bind pfl_loop pfl_loop_monitor u_mon (.ref_clk, .srst, .req, .bind_cfg, .pwm1_lut_duty,
  .pwm2_lut_duty, .rdata, .rvalid, .loop_duty, .pwm1_duty, .pwm2_duty);

// file: verif/pfl_loop_tb.sv
// Bench for pfl_loop: register access and loop outputs.
// Loop update shortened to 4 cycles; inputs change at falling edges.
`timescale 1ns/1ps
module pfl_loop_tb;
  import pfl_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  pfl_req_t   req = '0;
  pfl_bind_t  bnd = '0;
  logic [8:0] t1 = '0;
  logic [8:0] t2 = '0;
  logic [7:0] rdata, duty, p1, p2;
  logic [7:0] lut1 = 8'h11;
  logic [7:0] lut2 = 8'h22;
  logic       rvalid;
  int         err_count = 0;
  int         checks = 0;
  always #50 ref_clk = ~ref_clk;
  pfl_loop #(.UPDATE_CYC(4)) dut (.ref_clk, .srst, .req, .bind_cfg(bnd), .zone1_temp(t1),
    .zone2_temp(t2), .pwm1_lut_duty(lut1), .pwm2_lut_duty(lut2), .rdata, .rvalid,
    .loop_duty(duty), .pwm1_duty(p1), .pwm2_duty(p2));
  task automatic stop_test;
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    req = '0;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    req = '0;
    cmp($sformatf("reg %h", a), e, rdata);
    @(negedge ref_clk);
  endtask
  task automatic settle(logic [8:0] z1);
    t1 = z1;
    repeat (12) @(negedge ref_clk);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(8'h36 + i), (i == 3 || i == 4) ? 8'h80 : 8'h00);
    cmp("out1 lut", 8'h11, p1);
    cmp("out2 lut", 8'h22, p2);
    lut1 = 8'h5A;
    lut2 = 8'hA5;
    @(negedge ref_clk);
    cmp("out1 lut new", 8'h5A, p1);
    cmp("out2 lut new", 8'hA5, p2);
    for (int e = 0; e < 16; e++) begin
      wr(PFL_OFF_EXP, 8'(8'hA0 + e));
      rd(PFL_OFF_EXP, 8'(e));
    end
    for (int i = 0; i < 7; i++) wr(8'(8'h36 + i), 8'(8'hC5 + i));
    for (int i = 0; i < 7; i++) rd(8'(8'h36 + i), 8'(8'hC5 + i));
    wr(8'h3E, 8'h5A);
    rd(8'h3E, 8'h00);
    srst = 1'b1;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    wr(PFL_OFF_MIN_HYST, 8'h3F);
    wr(PFL_OFF_Z1_TGT, 8'h28);
    wr(PFL_OFF_P_GAIN, 8'h40);
    bnd = '{1'b1, 1'b0, 1'b1, 1'b1};
    t2 = 9'd200;
    settle(9'd80);
    cmp("floor", 8'h30, duty);
    cmp("out1", 8'h30, p1);
    cmp("out2", 8'h30, p2);
    // Error 60 half degrees times gain 40h, shifted by four
    settle(9'd140);
    cmp("hot", 8'hF0, duty);
    wr(PFL_OFF_EXP, 8'h08);
    settle(9'd140);
    cmp("exp -2", 8'h3C, duty);
    wr(PFL_OFF_EXP, 8'h04);
    wr(PFL_OFF_P_GAIN, 8'hFF);
    settle(9'd140);
    cmp("clamp", 8'hFF, duty);
    wr(PFL_OFF_Z1_OFF, 8'h46);
    settle(9'd140);
    cmp("off", 8'h00, duty);
    cmp("off out2", 8'h00, p2);
    wr(PFL_OFF_Z1_OFF, 8'h80);
    settle(9'd140);
    cmp("off unused", 8'hFF, duty);
    wr(PFL_OFF_MIN_HYST, 8'hF0);
    settle(9'd80);
    cmp("top floor", 8'hF0, duty);
    // Integral path only: saturates only with exponent +1 in time
    wr(PFL_OFF_MIN_HYST, 8'h00);
    wr(PFL_OFF_P_GAIN, 8'h00);
    wr(PFL_OFF_I_GAIN, 8'hFF);
    wr(PFL_OFF_EXP, 8'h01);
    repeat (15) settle(9'd140);
    cmp("integ sat", 8'hFF, duty);
    settle(9'd80);
    cmp("integ hold", 8'hFF, duty);
    wr(PFL_OFF_MIN_HYST, 8'h0F);
    settle(9'd66);
    cmp("hyst band", 8'hFF, duty);
    repeat (30) settle(9'd40);
    cmp("integ drain", 8'h00, duty);
    stop_test();
  end
endmodule // pfl_loop_tb
